// ### design/mpa_arbiter.sv
/*
 * matrix priority arbiter: priority register on axi4-lite and one
 * grant stage per slave port for six contending masters.
 * assumes requests synchronous to CLOCK; a master keeps its request
 * high for the whole transfer and drops it when done.
 */
// Summary of operation
// [RQ1] arbitrate only among simultaneous requests
// [RQ2] priority three highest, zero lowest
// [RQ3] equal priority: lower master number wins
// [RQ4] bits 1:0 instr, 3:2 data, reset zero
// [RQ5] bits 5:4 system, 9:8 dma, reset zero
// [RQ6] bits 15:14 fifo, 17:16 second core
// [RQ7] software keeps instr below data priority
// [RQ8] reserved bits written zero, read zero
// [RQ9] new priority applies at next decision
module mpa_arbiter #(
    parameter int NUM_SLAVES = 4
) (
    // clock and reset
    input  wire logic                                 CLOCK,
    input  wire logic                                 RST_B,
    // register bus
    input  wire mpa_pkg::mpa_axi_req_s                AXI_REQ,
    output mpa_pkg::mpa_axi_rsp_s                     AXI_RSP,
    // per slave port: master requests and one-hot grants
    input  wire mpa_pkg::mpa_vec_t [NUM_SLAVES-1:0]   MST_REQ,
    output mpa_pkg::mpa_vec_t [NUM_SLAVES-1:0]        MST_GNT
);
    import mpa_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_SLAVES < 1) begin : g_bad_slaves
        $error("NUM_SLAVES must be at least one");
    end

    for (genvar m = 0; m < MPA_NUM_MASTERS; m++) begin : g_field_chk
        if (MPA_PRIO_WMASK[MPA_FIELD_LSB[m] +: 2] != 2'h3) begin : g_bad_field
            $error("priority field outside the writable bits");
        end
    end

    // ------------------------------------------------------------
    // priority register and axi4-lite slave
    // ------------------------------------------------------------
    logic [31:0] prio_r;
    logic        aw_held_r;
    logic [11:0] aw_addr_r;
    logic        w_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        wr_go;
    logic [31:0] byte_mask;

    function automatic logic prio_hit(input logic [11:0] addr);
        return addr[11:2] == MPA_PRIO_OFFSET[11:2];
    endfunction

    assign wr_go = aw_held_r && w_held_r && !bvalid_r;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byte_mask[8*b +: 8] = {8{w_strb_r[b]}};
        end
    end

    // ------------------------------------------------------------
    // write address and data capture
    // ------------------------------------------------------------

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (!aw_held_r && AXI_REQ.awvalid) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= AXI_REQ.awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (!w_held_r && AXI_REQ.wvalid) begin
            w_held_r <= 1'b1;
            w_data_r <= AXI_REQ.wdata;
            w_strb_r <= AXI_REQ.wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // priority register
    // ------------------------------------------------------------

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            prio_r <= MPA_PRIO_RESET;                                    // [RQ4] [RQ5] [RQ6]
        end else if (wr_go && prio_hit(aw_addr_r)) begin
            prio_r <= ((prio_r & ~byte_mask) | (w_data_r & byte_mask))
                      & MPA_PRIO_WMASK;                                  // [RQ8]
        end
    end

    // ------------------------------------------------------------
    // write response
    // ------------------------------------------------------------

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            bvalid_r <= 1'b0;
            bresp_r  <= MPA_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= prio_hit(aw_addr_r) ? MPA_OKAY : MPA_SLVERR;
        end else if (AXI_REQ.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= MPA_OKAY;
        end else if (AXI_REQ.arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            if (prio_hit(AXI_REQ.araddr)) begin
                rdata_r <= prio_r;                                       // [RQ8]
                rresp_r <= MPA_OKAY;
            end else begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= MPA_SLVERR;
            end
        end else if (AXI_REQ.rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // response outputs
    // ------------------------------------------------------------

    always_comb begin
        AXI_RSP.awready = !aw_held_r;
        AXI_RSP.wready  = !w_held_r;
        AXI_RSP.bvalid  = bvalid_r;
        AXI_RSP.bresp   = bresp_r;
        AXI_RSP.arready = !rvalid_r;
        AXI_RSP.rvalid  = rvalid_r;
        AXI_RSP.rdata   = rdata_r;
        AXI_RSP.rresp   = rresp_r;
    end

    // ------------------------------------------------------------
    // winner selection
    // ------------------------------------------------------------
    function automatic mpa_vec_t pick_winner(input mpa_vec_t req, input logic [31:0] prio);
        mpa_vec_t   win;
        logic [1:0] best;
        logic       found;
        logic [1:0] p;
        win   = '0;
        best  = 2'h0;
        found = 1'b0;
        for (int m = 0; m < MPA_NUM_MASTERS; m++) begin
            p = prio[MPA_FIELD_LSB[m] +: 2];
            // strictly greater keeps the lower master on ties
            if (req[m] && (!found || p > best)) begin                   // [RQ2] [RQ3]
                win   = '0;
                win[m] = 1'b1;
                best  = p;
                found = 1'b1;
            end
        end
        return win;
    endfunction

    // ------------------------------------------------------------
    // grant stage per slave port
    // ------------------------------------------------------------
    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_port
        mpa_vec_t gnt_r;
        mpa_vec_t gnt_nxt;
        logic     busy;
        logic     lone;

        assign busy = |(gnt_r & MST_REQ[s]);
        assign lone = ($countones(MST_REQ[s]) == 1);

        always_comb begin
            if (busy) begin
                gnt_nxt = gnt_r;                                         // [RQ9]
            end else if (lone) begin
                gnt_nxt = MST_REQ[s];                                    // [RQ1]
            end else begin
                gnt_nxt = pick_winner(MST_REQ[s], prio_r);               // [RQ1] [RQ9]
            end
        end

        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                gnt_r <= '0;
            end else begin
                gnt_r <= gnt_nxt;
            end
        end

        assign MST_GNT[s] = gnt_r;
    end

endmodule

// ### design/mpa_pkg.sv
/*
 * package for the matrix priority arbiter: register map, field layout,
 * master numbering and the bus carrier structs.
 * assumes a single 50 MHz clock and an axi4-lite register port.
 */
package mpa_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] MPA_PRIO_OFFSET = 12'h004;
    localparam logic [31:0] MPA_PRIO_RESET  = 32'h0000_0000;
    localparam logic [31:0] MPA_PRIO_WMASK  = 32'h0003_C33F;

    // ------------------------------------------------------------
    // field positions, low bit of each two-bit field
    // ------------------------------------------------------------
    localparam int MPA_INSTR_LSB  = 0;
    localparam int MPA_DATA_LSB   = 2;
    localparam int MPA_SYSTEM_LSB = 4;
    localparam int MPA_DMA_LSB    = 8;
    localparam int MPA_FIFO_LSB   = 14;
    localparam int MPA_SECOND_LSB = 16;

    // ------------------------------------------------------------
    // masters, in ascending master number
    // ------------------------------------------------------------
    localparam int MPA_NUM_MASTERS = 6;
    typedef logic [MPA_NUM_MASTERS-1:0] mpa_vec_t;

    // master numbers 0, 1, 2, 4, 7, 8 in slot order
    localparam int MPA_FIELD_LSB [MPA_NUM_MASTERS] = '{
        MPA_INSTR_LSB, MPA_DATA_LSB, MPA_SYSTEM_LSB,
        MPA_DMA_LSB, MPA_FIFO_LSB, MPA_SECOND_LSB};

    localparam logic [1:0] MPA_OKAY   = 2'h0;
    localparam logic [1:0] MPA_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // axi4-lite carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } mpa_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mpa_axi_rsp_s;

endpackage

// ### verif/mpa_arb_chk.sv
/* checker on the mpa_arbiter ports; assumes the bind below, one clock */
module mpa_arb_chk import mpa_pkg::*; #(parameter int NUM_SLAVES = 4) (
    input wire logic                      CLOCK,
    input wire logic                      RST_B,
    input wire mpa_axi_req_s              AXI_REQ,
    input wire mpa_axi_rsp_s              AXI_RSP,
    input wire mpa_vec_t [NUM_SLAVES-1:0] MST_REQ,
    input wire mpa_vec_t [NUM_SLAVES-1:0] MST_GNT
);
    timeunit 1ns / 1ns;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    sequence wr_taken;
        AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready
            && !AXI_RSP.bvalid;
    endsequence
    wr_answer_a: assert property (wr_taken |=> ##1 AXI_RSP.bvalid) else $error("no bvalid");
    rd_answer_a: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
        else $error("no rvalid");
    b_stand_a: assert property (AXI_RSP.bvalid && !AXI_REQ.bready
        |=> AXI_RSP.bvalid && $stable(AXI_RSP.bresp)) else $error("bvalid lost");
    r_stand_a: assert property (AXI_RSP.rvalid && !AXI_REQ.rready
        |=> AXI_RSP.rvalid && $stable(AXI_RSP.rdata)) else $error("rvalid lost");
    ar_block_a: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready) else $error("arready");
    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_port
        one_grant_a: assert property ($onehot0(MST_GNT[s])) else $error("grants");
        gnt_valid_a: assert property (MST_GNT[s] != '0
            |-> (MST_GNT[s] & $past(MST_REQ[s])) != '0) else $error("grant without request");
        lone_win_a: assert property ($onehot(MST_REQ[s]) && MST_GNT[s] == '0
            |=> MST_GNT[s] == $past(MST_REQ[s])) else $error("lone");
        grant_hold_a: assert property ((MST_GNT[s] & MST_REQ[s]) != '0
            |=> $stable(MST_GNT[s])) else $error("hold");
        grant_drop_a: assert property (MST_GNT[s] != '0 && (MST_GNT[s] & MST_REQ[s]) == '0
            |=> (MST_GNT[s] & $past(MST_GNT[s])) == '0) else $error("drop");
    end
endmodule
bind mpa_arbiter mpa_arb_chk #(.NUM_SLAVES(NUM_SLAVES)) mpa_arb_chk_i (.CLOCK(CLOCK),
    .RST_B(RST_B), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .MST_REQ(MST_REQ), .MST_GNT(MST_GNT));

// ### verif/mpa_mst_model.sv
/* masters: a want pulse raises requests, each dropped two cycles after grant */
module mpa_mst_model import mpa_pkg::*; #(parameter int NUM_SLAVES = 4) (
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire mpa_vec_t [NUM_SLAVES-1:0] want,
    input  wire mpa_vec_t [NUM_SLAVES-1:0] gnt,
    output mpa_vec_t [NUM_SLAVES-1:0]      req
);
    timeunit 1ns / 1ns;
    mpa_vec_t [NUM_SLAVES-1:0] seen_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            req <= '0;
            seen_r <= '0;
        end else begin
            seen_r <= gnt & req;
            req <= (req | want) & ~(seen_r & gnt);
        end
    end
endmodule

// ### verif/tb_top.sv
/* bench for mpa_arbiter: register bus and arbitration; needs mpa_mst_model */
module tb_top;
    timeunit 1ns / 1ns;
    import mpa_pkg::*;
    logic           CLOCK = 1'h0;
    logic           RST_B = 1'h0;
    mpa_axi_req_s   req = '0;
    mpa_axi_rsp_s   rsp;
    mpa_vec_t [3:0] want = '0, mreq, gnt;
    logic [31:0]    rd;
    logic [1:0]     rs;
    int             err_total, total_checks, cyc;
    always #10 CLOCK = ~CLOCK;
    mpa_arbiter #(.NUM_SLAVES(4)) mpa_arbiter_i (.CLOCK(CLOCK), .RST_B(RST_B),
        .AXI_REQ(req), .AXI_RSP(rsp), .MST_REQ(mreq), .MST_GNT(gnt));
    mpa_mst_model #(.NUM_SLAVES(4)) mpa_mst_model_i (.clock(CLOCK), .rst_b(RST_B),
        .want(want), .gnt(gnt), .req(mreq));
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        err_total += int'(s !== e);
        if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input int hold = 0);
        int n;
        n = 0;
        @(posedge CLOCK);
        req <= '{awvalid: w, awaddr: a, wvalid: w, wdata: d, wstrb: 4'hF,
                 bready: w && hold == 0, arvalid: !w, araddr: a, rready: !w && hold == 0};
        do begin
            @(posedge CLOCK);
            n++;
            if (rsp.awready) req.awvalid <= 1'h0;
            if (rsp.wready) req.wvalid <= 1'h0;
            if (rsp.arready) req.arvalid <= 1'h0;
            if (n == hold) begin
                req.bready <= w;
                req.rready <= !w;
            end
        end while (!(rsp.bvalid === 1'h1 && req.bready) && !(rsp.rvalid === 1'h1 && req.rready));
        rd = rsp.rdata;
        rs = w ? rsp.bresp : rsp.rresp;
        req.bready <= 1'h0;
        req.rready <= 1'h0;
    endtask
    task automatic t_regs;
        bus(1'h0, 12'h004, '0);
        chk("reset", rd, 32'h0000_0000);
        bus(1'h1, 12'h004, 32'h0003_C33D);
        bus(1'h0, 12'h004, '0, 3);
        chk("fields", rd, 32'h0003_C33D);
        bus(1'h1, 12'h008, 32'h0000_0001, 3);
        chk("bad write", 32'(rs), 32'(MPA_SLVERR));
        bus(1'h0, 12'h008, '0);
        chk("bad read", {rd[29:0], rs}, 32'(MPA_SLVERR));
        $display("regs done");
    endtask
    task automatic t_arb(input int p, input logic [31:0] pr, input mpa_vec_t r, g1, g2);
        bus(1'h1, 12'h004, pr);
        @(posedge CLOCK);
        want[p] <= r;
        @(posedge CLOCK);
        want[p] <= '0;
        for (int k = 0; k < 9 && gnt[p] === '0; k++) @(posedge CLOCK);
        chk("first grant", 32'(gnt[p]), 32'(g1));
        for (int k = 0; k < 9 && gnt[p] === g1; k++) @(posedge CLOCK);
        chk("next grant", 32'(gnt[p]), 32'(g2));
        $display("arb %0d done", p);
    endtask
    initial begin
        repeat (6) @(posedge CLOCK);
        RST_B <= 1'h1;
        t_regs;
        t_arb(0, 32'h0000_0104, 6'h0A, 6'h02, 6'h08);
        t_arb(1, 32'h0000_0304, 6'h0A, 6'h08, 6'h02);
        t_arb(2, 32'h0003_C33C, 6'h01, 6'h01, 6'h00);
        t_arb(3, 32'h0003_C024, 6'h34, 6'h10, 6'h20);
        t_arb(0, 32'h0000_0009, 6'h07, 6'h02, 6'h01);
        complete_run;
    end
    always @(posedge CLOCK) begin
        if (++cyc == 2000) begin
            err_total++;
            complete_run;
        end
    end
endmodule
